// file: src/memory_peripheral_bus_port.sv
// memory and peripheral bus port: pin sequencer for external memories and peripherals
`timescale 1ns/1ps
module memory_peripheral_bus_port (
  input wire logic clock,
  input wire logic srst,
  input wire logic clock_enable,
  input wire logic cold_reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [memory_peripheral_bus_pkg::ADDR_W-1:0] req_address,
  input wire logic [memory_peripheral_bus_pkg::SEL_W-1:0] req_select,
  input wire logic [memory_peripheral_bus_pkg::DATA_W-1:0] req_wdata,
  input wire logic [memory_peripheral_bus_pkg::WAIT_W-1:0] wait_states,
  input wire logic [memory_peripheral_bus_pkg::POST_W-1:0] post_delay,
  input wire logic ack_mode,
  input wire logic [memory_peripheral_bus_pkg::SEL_COUNT-1:0] write_protect,
  input wire logic [memory_peripheral_bus_pkg::TIMER_W-1:0] timeout_cycles,
  input wire logic wait_or_ack_n,
  input wire logic [memory_peripheral_bus_pkg::DATA_W-1:0] data_in,
  output logic [memory_peripheral_bus_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [memory_peripheral_bus_pkg::ADDR_PIN_W-1:0] periph_address,
  output logic [memory_peripheral_bus_pkg::ADDR_HIGH_W-1:0] periph_address_high,
  output logic [memory_peripheral_bus_pkg::SEL_COUNT-1:0] device_select_n,
  output logic read_not_write,
  output logic read_output_enable_n,
  output logic write_strobe_n,
  output logic buffer_direction_n,
  output logic buffer_output_enable_n,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_error,
  output logic [memory_peripheral_bus_pkg::DATA_W-1:0] rsp_rdata,
  output logic warm_reset,
  output logic [memory_peripheral_bus_pkg::DATA_W-1:0] boot_vector,
  output logic boot_valid
);

  memory_peripheral_bus_pkg::state_type r_reg;
  memory_peripheral_bus_pkg::state_type r_next;
  logic done;
  logic timeout_hit;
  logic protected_write;

  // one-cold select pattern for a chip select number
  function automatic logic [memory_peripheral_bus_pkg::SEL_COUNT-1:0] select_decode(
    input logic [memory_peripheral_bus_pkg::SEL_W-1:0] sel
  );
    logic [memory_peripheral_bus_pkg::SEL_COUNT-1:0] pattern;
    pattern = memory_peripheral_bus_pkg::SEL_IDLE_N;
    pattern[sel] = 1'b0;
    return pattern;
  endfunction

  // completion wins over the timer if both land in the same cycle
  always_comb begin
    done = 1'b0;
    if (r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS &&
        r_reg.wait_cnt == memory_peripheral_bus_pkg::WAIT_ZERO) begin
      if (ack_mode) begin
        done = !wait_or_ack_n;
      end else begin
        done = wait_or_ack_n;
      end
    end
  end

  assign timeout_hit = r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS && !done &&
                       timeout_cycles != memory_peripheral_bus_pkg::TIMER_ZERO &&
                       r_reg.timer == timeout_cycles;
  assign protected_write = req_write && write_protect[req_select];

  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.rsp_error = 1'b0;
    r_next.warm_reset = 1'b0;
    r_next.in_cold = cold_reset;
    if (cold_reset) begin
      // bus parked and data pins released so the straps can be read
      r_next.phase = memory_peripheral_bus_pkg::PHASE_IDLE;
      r_next.sel_n = memory_peripheral_bus_pkg::SEL_IDLE_N;
      r_next.oe_n = 1'b1;
      r_next.we_n = 1'b1;
      r_next.boe_n = 1'b1;
      r_next.doe = 1'b0;
      r_next.boot_vector = data_in;
      r_next.boot_valid = 1'b0;
      r_next.ready = 1'b0;
    end else begin
      if (r_reg.in_cold) begin
        r_next.boot_valid = 1'b1;
      end
      case (r_reg.phase)
        memory_peripheral_bus_pkg::PHASE_IDLE: begin
          if (req_valid && r_reg.ready) begin
            if (protected_write) begin
              r_next.rsp_valid = 1'b1;
              r_next.rsp_error = 1'b1;
            end else begin
              r_next.phase = memory_peripheral_bus_pkg::PHASE_ACCESS;
              r_next.addr = req_address[memory_peripheral_bus_pkg::ADDR_PIN_W-1:0];
              r_next.addr_high =
                req_address[memory_peripheral_bus_pkg::ADDR_W-1:memory_peripheral_bus_pkg::ADDR_PIN_W];
              r_next.sel_n = select_decode(req_select);
              r_next.rnw = !req_write;
              r_next.oe_n = req_write;
              r_next.we_n = !req_write;
              r_next.bdir_n = req_write ? 1'b1 : 1'b0;
              r_next.boe_n = 1'b0;
              r_next.dout = req_wdata;
              r_next.doe = req_write;
              r_next.wait_cnt = wait_states;
              r_next.timer = memory_peripheral_bus_pkg::TIMER_ZERO;
            end
          end
        end
        memory_peripheral_bus_pkg::PHASE_ACCESS: begin
          r_next.timer = r_reg.timer + memory_peripheral_bus_pkg::TIMER_ONE;
          if (r_reg.wait_cnt != memory_peripheral_bus_pkg::WAIT_ZERO) begin
            r_next.wait_cnt = r_reg.wait_cnt - memory_peripheral_bus_pkg::WAIT_ONE;
          end
          if (done || timeout_hit) begin
            r_next.phase = memory_peripheral_bus_pkg::PHASE_POST;
            r_next.post_cnt = post_delay;
            r_next.sel_n = memory_peripheral_bus_pkg::SEL_IDLE_N;
            r_next.oe_n = 1'b1;
            r_next.we_n = 1'b1;
            r_next.boe_n = 1'b1;
            r_next.doe = 1'b0;
            r_next.rsp_valid = done;
            r_next.warm_reset = timeout_hit;
            if (done && r_reg.rnw) begin
              r_next.rdata = data_in;
            end
          end
        end
        memory_peripheral_bus_pkg::PHASE_POST: begin
          if (r_reg.post_cnt == memory_peripheral_bus_pkg::POST_ZERO) begin
            r_next.phase = memory_peripheral_bus_pkg::PHASE_IDLE;
          end else begin
            r_next.post_cnt = r_reg.post_cnt - memory_peripheral_bus_pkg::POST_ONE;
          end
        end
        default: begin
          r_next.phase = memory_peripheral_bus_pkg::PHASE_IDLE;
        end
      endcase
      // a refused write also drops ready for one cycle so each request answers once
      r_next.ready = r_next.phase == memory_peripheral_bus_pkg::PHASE_IDLE && !r_next.rsp_valid;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_reg.phase <= memory_peripheral_bus_pkg::PHASE_IDLE;
      r_reg.addr <= memory_peripheral_bus_pkg::ADDR_RESET;
      r_reg.addr_high <= memory_peripheral_bus_pkg::ADDR_HIGH_RESET;
      r_reg.sel_n <= memory_peripheral_bus_pkg::SEL_IDLE_N;
      r_reg.rnw <= 1'b1;
      r_reg.oe_n <= 1'b1;
      r_reg.we_n <= 1'b1;
      r_reg.bdir_n <= 1'b0;
      r_reg.boe_n <= 1'b1;
      r_reg.dout <= memory_peripheral_bus_pkg::DATA_RESET;
      r_reg.doe <= 1'b0;
      r_reg.wait_cnt <= memory_peripheral_bus_pkg::WAIT_ZERO;
      r_reg.post_cnt <= memory_peripheral_bus_pkg::POST_ZERO;
      r_reg.timer <= memory_peripheral_bus_pkg::TIMER_ZERO;
      r_reg.ready <= 1'b0;
      r_reg.rsp_valid <= 1'b0;
      r_reg.rsp_error <= 1'b0;
      r_reg.rdata <= memory_peripheral_bus_pkg::DATA_RESET;
      r_reg.warm_reset <= 1'b0;
      r_reg.boot_vector <= memory_peripheral_bus_pkg::DATA_RESET;
      r_reg.boot_valid <= 1'b0;
      r_reg.in_cold <= 1'b0;
    end else if (clock_enable) begin
      r_reg <= r_next;
    end
  end

  assign data_out = r_reg.dout;
  assign data_oe = r_reg.doe;
  assign periph_address = r_reg.addr;
  assign periph_address_high = r_reg.addr_high;
  assign device_select_n = r_reg.sel_n;
  assign read_not_write = r_reg.rnw;
  assign read_output_enable_n = r_reg.oe_n;
  assign write_strobe_n = r_reg.we_n;
  assign buffer_direction_n = r_reg.bdir_n;
  assign buffer_output_enable_n = r_reg.boe_n;
  assign req_ready = r_reg.ready;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_error = r_reg.rsp_error;
  assign rsp_rdata = r_reg.rdata;
  assign warm_reset = r_reg.warm_reset;
  assign boot_vector = r_reg.boot_vector;
  assign boot_valid = r_reg.boot_valid;

  a_one_select: assert property (@(posedge clock) disable iff (srst)
    $onehot0(~device_select_n)) else $error("more than one select asserted");
  a_read_strobe_ok: assert property (@(posedge clock) disable iff (srst)
    !read_output_enable_n |-> read_not_write && !data_oe &&
    device_select_n != memory_peripheral_bus_pkg::SEL_IDLE_N)
    else $error("output enable outside a read");
  a_write_strobe_ok: assert property (@(posedge clock) disable iff (srst)
    !write_strobe_n |-> !read_not_write && data_oe && !buffer_output_enable_n)
    else $error("write strobe outside a write");
  a_dir_follows_rnw: assert property (@(posedge clock) disable iff (srst)
    device_select_n != memory_peripheral_bus_pkg::SEL_IDLE_N |->
    buffer_direction_n == !read_not_write) else $error("buffer direction wrong");
  a_buffer_enable: assert property (@(posedge clock) disable iff (srst)
    !buffer_output_enable_n == (device_select_n != memory_peripheral_bus_pkg::SEL_IDLE_N))
    else $error("buffer enable out of step with select");
  a_boot_capture: assert property (@(posedge clock) disable iff (srst)
    cold_reset && clock_enable |=> !data_oe && boot_vector == $past(data_in))
    else $error("boot vector not captured");
  a_wait_extends: assert property (@(posedge clock) disable iff (srst)
    r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS && !ack_mode && !wait_or_ack_n &&
    !timeout_hit && !cold_reset && clock_enable |=>
    r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS && !rsp_valid)
    else $error("cycle ended while wait asserted");
  a_ack_finishes: assert property (@(posedge clock) disable iff (srst)
    r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS && ack_mode && !wait_or_ack_n &&
    r_reg.wait_cnt == memory_peripheral_bus_pkg::WAIT_ZERO && !cold_reset && clock_enable |=>
    rsp_valid && device_select_n == memory_peripheral_bus_pkg::SEL_IDLE_N)
    else $error("acknowledge did not end the access");
  a_protect_blocks: assert property (@(posedge clock) disable iff (srst)
    req_valid && req_ready && protected_write && !cold_reset && clock_enable |=>
    rsp_error && rsp_valid && write_strobe_n) else $error("protected write not blocked");
  a_timeout_warm: assert property (@(posedge clock) disable iff (srst)
    timeout_hit && !cold_reset && clock_enable |=> warm_reset && !rsp_valid)
    else $error("timer expiry gave no warm reset");
  a_wait_states_held: assert property (@(posedge clock) disable iff (srst)
    r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS &&
    r_reg.wait_cnt != memory_peripheral_bus_pkg::WAIT_ZERO && !timeout_hit &&
    !cold_reset && clock_enable |=> r_reg.phase == memory_peripheral_bus_pkg::PHASE_ACCESS)
    else $error("access ended inside wait states");
endmodule

// file: src/memory_peripheral_bus_pkg.sv
// constants and types shared by the memory and peripheral bus port
package memory_peripheral_bus_pkg;
  localparam int ADDR_PIN_W = 22;
  localparam int ADDR_HIGH_W = 4;
  localparam int ADDR_W = ADDR_PIN_W + ADDR_HIGH_W;
  localparam int DATA_W = 8;
  localparam int SEL_COUNT = 4;
  localparam int SEL_W = 2;
  localparam int WAIT_W = 6;
  localparam int POST_W = 5;
  localparam int TIMER_W = 16;
  localparam logic [SEL_COUNT-1:0] SEL_IDLE_N = 4'hF;
  localparam logic [ADDR_PIN_W-1:0] ADDR_RESET = 22'h000000;
  localparam logic [ADDR_HIGH_W-1:0] ADDR_HIGH_RESET = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 6'h00;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 6'h01;
  localparam logic [POST_W-1:0] POST_ZERO = 5'h00;
  localparam logic [POST_W-1:0] POST_ONE = 5'h01;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 16'h0001;

  typedef enum logic [1:0] {
    PHASE_IDLE,
    PHASE_ACCESS,
    PHASE_POST
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [ADDR_PIN_W-1:0] addr;
    logic [ADDR_HIGH_W-1:0] addr_high;
    logic [SEL_COUNT-1:0] sel_n;
    logic rnw;
    logic oe_n;
    logic we_n;
    logic bdir_n;
    logic boe_n;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic [WAIT_W-1:0] wait_cnt;
    logic [POST_W-1:0] post_cnt;
    logic [TIMER_W-1:0] timer;
    logic ready;
    logic rsp_valid;
    logic rsp_error;
    logic [DATA_W-1:0] rdata;
    logic warm_reset;
    logic [DATA_W-1:0] boot_vector;
    logic boot_valid;
    logic in_cold;
  } state_type;
endpackage

// file: tb/periph_device_model.sv
// behavioural external memory answering the peripheral bus pins
`timescale 1ns/1ps
module periph_device_model (
  input wire logic clock,
  input wire logic cold_reset,
  input wire logic ack_mode,
  input wire logic [7:0] stall,
  input wire logic [7:0] boot_value,
  input wire logic [3:0] device_select_n,
  input wire logic read_output_enable_n,
  input wire logic write_strobe_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [21:0] periph_address,
  output logic wait_or_ack_n,
  output logic [7:0] data_in
);
  logic [7:0] mem [0:255];
  logic [7:0] cnt = 8'h00;
  logic [7:0] last = 8'h00;
  logic sel;
  assign sel = (device_select_n != 4'hF);
  always @(posedge clock) begin
    cnt <= sel ? cnt + 8'h01 : 8'h00;
    last <= data_in;
    if (sel && !write_strobe_n && data_oe) begin
      mem[periph_address[7:0]] <= data_out;
    end
  end
  // wait is low early in the access, acknowledge low late
  assign wait_or_ack_n = !sel || (ack_mode ? (cnt < stall) : (cnt >= stall));
  always_comb begin
    if (cold_reset) begin
      data_in = boot_value;
    end else if (sel && !read_output_enable_n) begin
      data_in = mem[periph_address[7:0]];
    end else begin
      // released bus: no pull, so show a changing pattern rather than the last value
      data_in = ~last;
    end
  end
endmodule

// file: tb/memory_peripheral_bus_port_bench.sv
// self-checking bench for the memory and peripheral bus port
`timescale 1ns/1ps
module memory_peripheral_bus_port_bench;
  logic clock = 1'b0;
  logic srst, cold_reset, req_valid, req_write, ack_mode, wait_or_ack_n, data_oe;
  logic read_not_write, read_output_enable_n, write_strobe_n, buffer_direction_n;
  logic buffer_output_enable_n, req_ready, rsp_valid, rsp_error, warm_reset, boot_valid;
  logic [25:0] req_address;
  logic [21:0] periph_address;
  logic [15:0] timeout_cycles;
  logic [7:0] req_wdata, data_in, data_out, rsp_rdata, boot_vector, stall, boot_value;
  logic [5:0] wait_states;
  logic [4:0] post_delay;
  logic [3:0] write_protect, device_select_n, periph_address_high;
  logic [1:0] req_select;
  logic clock_enable;
  int n_fail = 0;
  int compares = 0;

  memory_peripheral_bus_port DUT (.clock, .srst, .clock_enable, .cold_reset,
    .req_valid, .req_write, .req_address, .req_select, .req_wdata, .wait_states,
    .post_delay, .ack_mode, .write_protect, .timeout_cycles, .wait_or_ack_n, .data_in,
    .data_out, .data_oe, .periph_address, .periph_address_high, .device_select_n,
    .read_not_write, .read_output_enable_n, .write_strobe_n, .buffer_direction_n,
    .buffer_output_enable_n, .req_ready, .rsp_valid, .rsp_error, .rsp_rdata, .warm_reset,
    .boot_vector, .boot_valid);
  periph_device_model partner (.clock, .cold_reset, .ack_mode, .stall, .boot_value,
    .device_select_n, .read_output_enable_n, .write_strobe_n, .data_out, .data_oe,
    .periph_address, .wait_or_ack_n, .data_in);

  always #4 clock = ~clock;

  task automatic step;
    @(posedge clock);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic [25:0] adr(input int i);
    return {4'(15 - i), 14'h2AAA, 8'(16 * i + 3)};
  endfunction

  // one request; d is write data, or the data a read should return
  task automatic access(input logic wr, input logic [25:0] a, input logic [1:0] s,
    input logic [7:0] d, input int len_exp, input logic err, input logic warm);
    int len;
    int n;
    len = 0;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      step();
      n++;
    end
    req_valid = 1'b1;
    req_write = wr;
    req_address = a;
    req_select = s;
    req_wdata = d;
    step();
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && warm_reset !== 1'b1 && n < 300) begin
      if (device_select_n !== 4'hF) begin
        len++;
        chk("select", device_select_n, 4'(~(4'h1 << s)));
        chk("rnw", read_not_write, !wr);
        chk("oe_n", read_output_enable_n, wr);
        chk("we_n", write_strobe_n, !wr);
        chk("bdir_n", buffer_direction_n, wr);
        chk("boe_n", buffer_output_enable_n, 1'b0);
        chk("address", {periph_address_high, periph_address}, a);
        chk("data drive", {data_oe, data_out & {8{wr}}}, {wr, d & {8{wr}}});
      end
      step();
      n++;
    end
    chk("access cycles", len, len_exp);
    chk("error", rsp_error, err);
    chk("warm reset", warm_reset, warm);
    if (!wr && !warm) chk("read data", rsp_rdata, d);
    if (!err && !warm) begin
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
        step();
        n++;
      end
      chk("post gap", n, post_delay + 1);
    end
  endtask

  task automatic boot_check;
    repeat (3) step();
    chk("ready in cold", req_ready, 1'b0);
    cold_reset = 1'b0;
    step();
    chk("boot vector", boot_vector, 8'hA5);
    chk("boot valid", boot_valid, 1'b1);
  endtask

  // write then read back on every select, wait states and gaps up to their limits
  task automatic rw_check;
    for (int i = 0; i < 4; i++) begin
      wait_states = 6'(i * 21);
      post_delay = (i == 3) ? 5'h1F : 5'(i * 10);
      access(1'b1, adr(i), 2'(i), 8'(60 + i), i * 21 + 1, 1'b0, 1'b0);
      access(1'b0, adr(i), 2'(i), 8'(60 + i), i * 21 + 1, 1'b0, 1'b0);
    end
  endtask

  task automatic ext_check;
    wait_states = 6'h02;
    post_delay = 5'h00;
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 2; k++) begin
        ack_mode = m[0];
        stall = k ? 8'h01 : 8'h05;
        access(1'b0, adr(0), 2'h0, 8'h3C, k ? 3 : 6, 1'b0, 1'b0);
      end
    end
  endtask

  task automatic protect_check;
    ack_mode = 1'b0;
    stall = 8'h00;
    write_protect = 4'h4;
    access(1'b1, adr(2), 2'h2, 8'h99, 0, 1'b1, 1'b0);
    write_protect = 4'h0;
    // the old byte must survive the blocked write
    access(1'b0, adr(2), 2'h2, 8'h3E, 3, 1'b0, 1'b0);
  endtask

  // a frozen port must not take a request that stands at its inputs
  task automatic freeze_check;
    clock_enable = 1'b0;
    req_valid = 1'b1;
    req_write = 1'b0;
    req_address = adr(3);
    req_select = 2'h3;
    repeat (4) step();
    chk("frozen select", device_select_n, 4'hF);
    chk("frozen oe_n", read_output_enable_n, 1'b1);
    req_valid = 1'b0;
    clock_enable = 1'b1;
    step();
    access(1'b0, adr(3), 2'h3, 8'h3F, 3, 1'b0, 1'b0);
  endtask

  task automatic timeout_check;
    ack_mode = 1'b1;
    stall = 8'hC8;
    wait_states = 6'h00;
    timeout_cycles = 16'h0005;
    access(1'b0, adr(1), 2'h1, 8'h00, 6, 1'b0, 1'b1);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    clock_enable = 1'b1;
    cold_reset = 1'b1;
    {req_valid, req_write, ack_mode} = 3'h0;
    {req_address, req_select, req_wdata} = '0;
    {wait_states, post_delay, write_protect, timeout_cycles} = '0;
    stall = 8'h00;
    boot_value = 8'hA5;
    repeat (5) @(posedge clock);
    #1;
    srst = 1'b0;
    boot_check();
    rw_check();
    ext_check();
    protect_check();
    freeze_check();
    timeout_check();
    report_and_stop();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    report_and_stop();
  end
endmodule
